// ### rtl/conv_ctrl_top.sv
// control registers of the sigma-delta converter behind an Avalon-MM slave
// assumes synchronous active-low reset; standby and request inputs come from other domains
`timescale 1ns/1ps
module conv_ctrl_top
(
   input  wire logic                              clock,
   input  wire logic                              rst_n,
   input  wire logic [conv_ctrl_pkg::ADDR_W-1:0]  address,
   input  wire logic                              read,
   input  wire logic                              write,
   input  wire logic [conv_ctrl_pkg::DATA_W-1:0]  writedata,
   input  wire logic [3:0]                        byteenable,
   output logic      [conv_ctrl_pkg::DATA_W-1:0]  readdata,
   output logic                                   waitrequest,
   input  wire logic                              standby_sleep,
   input  wire logic                              periph_request,
   output logic                                   converter_run,
   output logic                                   converter_enabled
);
   import conv_ctrl_pkg::*;

   control_a_t        ctrl;
   logic [REG_W-1:0]  reference_selection_control;
   logic              en_sent;
   logic              en_conv;
   logic              en_inflight;
   logic              sr_busy;
   logic              sr_active;
   logic [3:0]        div_count;
   logic              conv_tick;
   logic [1:0]        standby_sync;
   logic [1:0]        request_sync;
   logic              standby_s;
   logic              request_s;
   logic [1:0]        index;
   logic              acc_write;
   logic              wr_ctrl;
   logic              wr_ref;
   logic              en_launch;
   logic              sr_launch;
   sync_busy_flags_t  sync_busy_flags;
   control_a_t        wdata;
   logic              next_run;

   assign index     = address[3:2];
   assign acc_write = write && !waitrequest && byteenable[0];
   assign wdata     = control_a_t'(writedata[REG_W-1:0]);
   // a soft reset runs until its own handshake and the disable it causes have both landed
   assign sr_active = sr_busy || ctrl.soft_reset_bit;
   // writes to the control registers are held off while a soft reset runs
   assign wr_ctrl   = acc_write && index == IDX_CONTROL_A && !sr_active;
   assign wr_ref    = acc_write && index == IDX_REFERENCE && !sr_active
                      && !ctrl.enable && !sync_busy_flags.enable;
   assign standby_s = standby_sync[1];
   assign request_s = request_sync[1];

   ////////////////////////////////////////////////////////////////////////////
   // converter rate and input synchronisers
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         div_count <= 4'h0;
         conv_tick <= 1'b0;
      end
      else
      begin
         conv_tick <= div_count == CONV_DIV_LAST;
         div_count <= (div_count == CONV_DIV_LAST) ? 4'h0 : div_count + 4'h1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         standby_sync <= 2'b00;
         request_sync <= 2'b00;
      end
      else
      begin
         standby_sync <= {standby_sync[0], standby_sleep};
         request_sync <= {request_sync[0], periph_request};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, then a single-cycle answer
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         waitrequest <= 1'b1;
      else
         waitrequest <= !((read || write) && waitrequest);
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         readdata <= READ_ZERO;
      else if (read && waitrequest)
      begin
         unique case (index)
            IDX_CONTROL_A : readdata <= {24'h00_0000, ctrl};
            IDX_REFERENCE : readdata <= {24'h00_0000, reference_selection_control};
            IDX_SYNC_BUSY : readdata <= {30'h0000_0000, sync_busy_flags};
            IDX_STATUS    : readdata <= {30'h0000_0000, converter_enabled, converter_run};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         ctrl <= control_a_t'(CONTROL_A_INIT);
      else if (wr_ctrl && wdata.soft_reset_bit)
      begin
         ctrl                <= control_a_t'(CONTROL_A_INIT);
         ctrl.soft_reset_bit <= 1'b1;
      end
      else if (wr_ctrl)
      begin
         ctrl.enable              <= wdata.enable;
         ctrl.run_in_standby      <= wdata.run_in_standby;
         ctrl.on_demand_operation <= wdata.on_demand_operation;
      end
      // bit clears on completion
      // waiting for the enable handshake too keeps the converter from waking between the two
      else if (!sr_busy && !sync_busy_flags.enable)
         ctrl.soft_reset_bit <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         reference_selection_control <= REFERENCE_INIT;
      else if (wr_ctrl && wdata.soft_reset_bit)
         reference_selection_control <= REFERENCE_INIT;
      else if (wr_ref)
         reference_selection_control <= writedata[REG_W-1:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable crosses late
   // the launcher resends whenever stored and sent values disagree and no handshake is in flight
   assign en_launch = (ctrl.enable != en_sent) && !en_inflight;
   assign sr_launch = wr_ctrl && wdata.soft_reset_bit;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         en_sent <= 1'b0;
      else if (en_launch)
         en_sent <= ctrl.enable;
   end

   conv_sync_handshake u_enable_sync
   (
      .clock        (clock),
      .rst_n        (rst_n),
      .conv_tick    (conv_tick),
      .launch       (en_launch),
      .launch_value (ctrl.enable),
      .conv_value   (en_conv),
      .busy         (en_inflight),
      .done         ()
   );

   conv_sync_handshake u_reset_sync
   (
      .clock        (clock),
      .rst_n        (rst_n),
      .conv_tick    (conv_tick),
      .launch       (sr_launch),
      .launch_value (1'b1),
      .conv_value   (),
      .busy         (sr_busy),
      .done         ()
   );

   always_comb
   begin
      sync_busy_flags.enable     = en_inflight || (ctrl.enable != en_sent);
      sync_busy_flags.soft_reset = ctrl.soft_reset_bit;
   end

   ////////////////////////////////////////////////////////////////////////////
   // run decision
   always_comb
   begin
      next_run = en_conv && !sr_active;
      if (standby_s && !ctrl.run_in_standby)
         next_run = 1'b0;
      if (ctrl.on_demand_operation && !request_s)
         next_run = 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         converter_run     <= 1'b0;
         converter_enabled <= 1'b0;
      end
      else
      begin
         converter_run     <= next_run;
         converter_enabled <= en_conv && !sr_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_enable_delayed;
      @(posedge clock) disable iff (!rst_n)
      (wr_ctrl && !wdata.soft_reset_bit && wdata.enable && !en_conv) |=> !en_conv [*3];
   endproperty
   a_enable_delayed : assert property (p_enable_delayed) else $error("enable took effect at once");

   property p_enable_readback;
      @(posedge clock) disable iff (!rst_n)
      (wr_ctrl && !wdata.soft_reset_bit) |=> ctrl.enable == $past(writedata[BIT_ENABLE]);
   endproperty
   a_enable_readback : assert property (p_enable_readback) else $error("enable not read back");

   property p_enable_busy;
      @(posedge clock) disable iff (!rst_n)
      (wr_ctrl && !wdata.soft_reset_bit && wdata.enable != ctrl.enable)
         |=> sync_busy_flags.enable ##[1:40] !sync_busy_flags.enable;
   endproperty
   a_enable_busy : assert property (p_enable_busy) else $error("enable busy wrong");

   property p_zero_no_reset;
      @(posedge clock) disable iff (!rst_n)
      (wr_ctrl && !wdata.soft_reset_bit) |=> !ctrl.soft_reset_bit;
   endproperty
   a_zero_no_reset : assert property (p_zero_no_reset) else $error("zero started a reset");

   property p_reset_wins;
      @(posedge clock) disable iff (!rst_n)
      (wr_ctrl && wdata.soft_reset_bit)
         |=> !ctrl.enable && !ctrl.run_in_standby && !ctrl.on_demand_operation
             && reference_selection_control == REFERENCE_INIT && ctrl.soft_reset_bit;
   endproperty
   a_reset_wins : assert property (p_reset_wins) else $error("soft reset did not win");

   property p_reset_disables;
      @(posedge clock) disable iff (!rst_n)
      (wr_ctrl && wdata.soft_reset_bit) |=> ##1 !converter_run && !converter_enabled;
   endproperty
   a_reset_disables : assert property (p_reset_disables) else $error("converter left running");

   property p_reset_ends_disabled;
      @(posedge clock) disable iff (!rst_n)
      $fell(ctrl.soft_reset_bit) |-> !en_conv && !converter_enabled;
   endproperty
   a_reset_ends_disabled : assert property (p_reset_ends_disabled) else $error("enabled after reset");

   property p_reset_clears;
      @(posedge clock) disable iff (!rst_n)
      $rose(ctrl.soft_reset_bit) |-> ctrl.soft_reset_bit [*4] ##[1:40] !ctrl.soft_reset_bit;
   endproperty
   a_reset_clears : assert property (p_reset_clears) else $error("soft reset never clears");

   property p_standby_halt;
      @(posedge clock) disable iff (!rst_n)
      (standby_s && !ctrl.run_in_standby) |=> !converter_run;
   endproperty
   a_standby_halt : assert property (p_standby_halt) else $error("ran in standby");

   property p_on_demand;
      @(posedge clock) disable iff (!rst_n)
      (ctrl.on_demand_operation && !request_s) |=> !converter_run;
   endproperty
   a_on_demand : assert property (p_on_demand) else $error("ran without request");

   property p_standby_run;
      @(posedge clock) disable iff (!rst_n)
      (en_conv && !sr_active && ctrl.run_in_standby && standby_s && !ctrl.on_demand_operation)
         |=> converter_run;
   endproperty
   a_standby_run : assert property (p_standby_run) else $error("halted in standby");

   property p_disabled_off;
      @(posedge clock) disable iff (!rst_n)
      !en_conv |=> !converter_run;
   endproperty
   a_disabled_off : assert property (p_disabled_off) else $error("ran while disabled");

   c_enable_done  : cover property (@(posedge clock) disable iff (!rst_n) $fell(sync_busy_flags.enable));
   c_reset_done   : cover property (@(posedge clock) disable iff (!rst_n) $fell(ctrl.soft_reset_bit));
   c_demand_run   : cover property (@(posedge clock) disable iff (!rst_n)
                                    converter_run && ctrl.on_demand_operation);
   c_standby_run  : cover property (@(posedge clock) disable iff (!rst_n) converter_run && standby_s);

endmodule

// ### rtl/conv_ctrl_pkg.sv
// constants, field layouts and types for the converter control block
// assumes one 100 MHz clock and an Avalon-MM master on the register side
// Contract
// - run-in-standby keeps converter running in standby
// - run-in-standby clear halts converter in standby
// - on-demand runs only while a peripheral requests
// - enable change acts after synchronisation delay
// - enable reads back at once, busy flag pulses
// - enable zero disables, one enables converter
// - writing zero to soft reset does nothing
// - soft reset restores registers, converter disabled
// - soft reset discards other fields of write
// - soft reset and busy clear when done
package conv_ctrl_pkg;

   // register indices; byte address is four times the index
   localparam logic [1:0] IDX_CONTROL_A  = 2'h0;
   localparam logic [1:0] IDX_REFERENCE  = 2'h1;
   localparam logic [1:0] IDX_SYNC_BUSY  = 2'h2;
   localparam logic [1:0] IDX_STATUS     = 2'h3;
   localparam int         ADDR_W         = 4;
   localparam int         DATA_W         = 32;
   localparam int         REG_W          = 8;

   // converter_control_a fields
   localparam int         BIT_SOFT_RESET = 0;
   localparam int         BIT_ENABLE     = 1;
   localparam int         BIT_RUN_STDBY  = 6;
   localparam int         BIT_ON_DEMAND  = 7;

   localparam logic [7:0] CONTROL_A_INIT = 8'h00;
   localparam logic [7:0] REFERENCE_INIT = 8'h00;
   localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

   // converter clock is the bus clock divided down
   localparam int         CLOCK_MHZ      = 100;
   localparam int         CONV_MHZ       = 25;
   localparam int         CONV_DIV       = CLOCK_MHZ / CONV_MHZ;
   localparam logic [3:0] CONV_DIV_LAST  = 4'(CONV_DIV - 1);

   typedef struct packed {
      logic       on_demand_operation;
      logic       run_in_standby;
      logic [3:0] unused;
      logic       enable;
      logic       soft_reset_bit;
   } control_a_t;

   typedef struct packed {
      logic soft_reset;
      logic enable;
   } sync_busy_flags_t;

endpackage

// ### rtl/conv_sync_handshake.sv
// toggle handshake carrying one bit into the converter-rate logic
// assumes conv_tick is a one-cycle pulse on the same clock; launch only while busy is low
`timescale 1ns/1ps
module conv_sync_handshake
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic conv_tick,
   input  wire logic launch,
   input  wire logic launch_value,
   output logic      conv_value,
   output logic      busy,
   output logic      done
);
   import conv_ctrl_pkg::*;

   logic req;
   logic hold;
   logic req_s1;
   logic req_s2;
   logic ack;
   logic ack_s1;
   logic ack_s2;
   logic ack_s3;

   ////////////////////////////////////////////////////////////////////////////
   // request toggle
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         req  <= 1'b0;
         hold <= 1'b0;
      end
      else if (launch && !busy)
      begin
         req  <= ~req;
         hold <= launch_value;
      end
   end

   // converter side only moves on its own rate
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         req_s1     <= 1'b0;
         req_s2     <= 1'b0;
         ack        <= 1'b0;
         conv_value <= 1'b0;
      end
      else if (conv_tick)
      begin
         req_s1 <= req;
         req_s2 <= req_s1;
         if (req_s2 != ack)
         begin
            ack        <= req_s2;
            conv_value <= hold;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_s3 <= 1'b0;
      end
      else
      begin
         ack_s1 <= ack;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
      end
   end

   assign busy = req ^ ack_s2;
   assign done = ack_s2 ^ ack_s3;

   ////////////////////////////////////////////////////////////////////////////
   property p_busy_held;
      @(posedge clock) disable iff (!rst_n)
      (launch && !busy) |=> busy [*4];
   endproperty
   a_busy_held : assert property (p_busy_held) else $error("busy dropped too early");

   property p_value_delivered;
      @(posedge clock) disable iff (!rst_n)
      $fell(busy) |-> conv_value == hold;
   endproperty
   a_value_delivered : assert property (p_value_delivered) else $error("value not delivered");

endmodule

// ### sim/sigma_delta_adc_control_test.sv
// self-checking bench for the converter control block: registers, enable, soft reset, run modes
// assumes the design answers each Avalon request after one wait cycle and a 100 MHz clock
`timescale 1ns/1ps
module sigma_delta_adc_control_test;
   import conv_ctrl_pkg::*;

   localparam logic [3:0] A_CTL  = {IDX_CONTROL_A, 2'h0};
   localparam logic [3:0] A_REF  = {IDX_REFERENCE, 2'h0};
   localparam logic [3:0] A_BUSY = {IDX_SYNC_BUSY, 2'h0};
   localparam logic [3:0] A_STAT = {IDX_STATUS, 2'h0};

   logic                clock;
   logic                rst_n;
   logic [ADDR_W-1:0]   address;
   logic                read;
   logic                write;
   logic [DATA_W-1:0]   writedata;
   logic [3:0]          byteenable;
   logic [DATA_W-1:0]   readdata;
   logic                waitrequest;
   logic                standby_sleep;
   logic                periph_request;
   logic                converter_run;
   logic                converter_enabled;
   int                  error_cnt;
   int                  check_count;
   int                  seed;
   logic [31:0]         rv;
   logic [31:0]         wd;
   logic [3:0]          m;

   conv_ctrl_top dut
   (
      .clock             (clock),
      .rst_n             (rst_n),
      .address           (address),
      .read              (read),
      .write             (write),
      .writedata         (writedata),
      .byteenable        (byteenable),
      .readdata          (readdata),
      .waitrequest       (waitrequest),
      .standby_sleep     (standby_sleep),
      .periph_request    (periph_request),
      .converter_run     (converter_run),
      .converter_enabled (converter_enabled)
   );

   always #5 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task results;
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // request held until the edge that samples waitrequest low
   task bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
            output logic [31:0] q);
      @(posedge clock);
      read       <= rd;
      write      <= ~rd;
      address    <= a;
      writedata  <= d;
      byteenable <= be;
      // only the watchdog ends a wait that never gets an answer
      do
      begin
         @(posedge clock);
      end
      while (waitrequest !== 1'b0);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b0, a, d, 4'hF, rv);
   endtask

   task rd(input logic [3:0] a);
      bus(1'b1, a, 32'h0, 4'hF, rv);
   endtask

   // polling is bounded: a stuck handshake shows up as a nonzero busy value
   task wait_sync;
      int n;
      n = 0;
      do
      begin
         rd(A_BUSY);
         n++;
      end
      while (rv !== 32'h0 && n < 40);
   endtask

   // behavioural run condition of the converter side
   function automatic logic run_model(int od, int rs, int sb, int rq);
      return !(sb != 0 && rs == 0) && !(od != 0 && rq == 0);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      results;
   end

   initial
   begin
      clock = 1'b0;
      rst_n = 1'b0;
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'h0;
      standby_sleep = 1'b0;
      periph_request = 1'b0;
      error_cnt = 0;
      check_count = 0;
      seed = 79514;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         rd(4'(i * 4));
         check(rv, 32'h0);
      end
      wd = $random(seed);
      wr(A_REF, wd);
      bus(1'b0, A_REF, ~wd, 4'hE, rv);
      rd(A_REF);
      check(rv, {24'h0, wd[7:0]});
      // enable delayed, read back at once
      wr(A_CTL, 32'h0000_0002);
      check({31'h0, converter_enabled}, 32'h0);
      rd(A_CTL);
      check(rv, 32'h0000_0002);
      rd(A_BUSY);
      check(rv, 32'h0000_0001);
      wait_sync;
      check(rv, 32'h0);
      check({31'h0, converter_enabled}, 32'h1);
      rd(A_STAT);
      check(rv, 32'h0000_0003);
      for (int i = 0; i < 16; i++)
      begin
         m = 4'(i ^ ($random(seed) & 0));
         wr(A_CTL, {24'h0, m[3], m[2], 6'h02});
         standby_sleep  <= m[1];
         periph_request <= m[0];
         repeat (8) @(posedge clock);
         check({31'h0, converter_run}, {31'h0, run_model(m[3], m[2], m[1], m[0])});
      end
      rd(A_CTL);
      check(rv, 32'h0000_00C2);
      standby_sleep <= 1'b0;
      wr(A_CTL, 32'h0);
      wait_sync;
      check({30'h0, converter_enabled, converter_run}, 32'h0);
      // soft reset wins over the rest of the write
      wd = $random(seed) | 32'h1;
      wr(A_REF, wd);
      wr(A_CTL, 32'h0000_0002);
      wait_sync;
      wr(A_CTL, 32'h0000_00C3);
      rd(A_CTL);
      check(rv, 32'h0000_0001);
      rd(A_BUSY);
      check(rv & 32'h2, 32'h2);
      rd(A_REF);
      check(rv, 32'h0);
      check({31'h0, converter_enabled}, 32'h0);
      wait_sync;
      check(rv, 32'h0);
      check({30'h0, converter_enabled, converter_run}, 32'h0);
      rd(A_CTL);
      check(rv, 32'h0);
      // hardware reset through rst_n right after the enable write, before it synchronises
      wr(A_CTL, 32'h0000_0042);
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      rd(A_CTL);
      check(rv, 32'h0);
      check({31'h0, converter_enabled}, 32'h0);
      results;
   end
endmodule
